// file: logic/scc_map.vh
// Purpose: Register offsets, field positions and reset values for the clock control block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Registers are 16 bits wide; upper bits read as zero
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

`define SCC_OFF_GATE0       12'h000
`define SCC_OFF_GATE1       12'h004
`define SCC_OFF_GATE2       12'h008
`define SCC_OFF_GATE3       12'h00c
`define SCC_OFF_MPLL_CTL    12'h010
`define SCC_OFF_MPLL_STS    12'h014
`define SCC_OFF_SPLL_CFG    12'h018
`define SCC_OFF_SPLL_MULT   12'h01c
`define SCC_OFF_SPLL_STS    12'h020
`define SCC_OFF_AUX_CNT     12'h024
`define SCC_OFF_PWM_CFG     12'h028
`define SCC_OFF_IRQ_STS     12'h02c
`define SCC_OFF_IRQ_MASK    12'h030

`define SCC_RST_GATE        16'h0000
`define SCC_RST_MPLL_CTL    5'h00
`define SCC_RST_SCALER      2'h0
`define SCC_RST_SPLL_MULT   4'h0
`define SCC_MPLL_MULT_MAX   5'h10

// Second PLL config: bit 0 enable, bits 2:1 source (0 = crystal input)
`define SCC_SPLL_EN_BIT     0
`define SCC_SPLL_SRC_LSB    1
`define SCC_SPLL_SRC_XTAL   2'h0
// Main PLL status: output scaler select bits 8:7
`define SCC_SCALER_LSB      7

// Interrupt status bits
`define SCC_IRQ_LOCK        0
`define SCC_IRQ_UNLOCK      1
`define SCC_IRQ_WRAP        2

// Lock time in second PLL reference cycles (modelled on pclk)
`define SCC_LOCK_CYCLES     16'd1024

`endif

// file: logic/scc_clock_ctrl.v
// Purpose: System clock control registers, second PLL control and aux clock counter
// Assumes: APB slave on pclk; aux_clk is a free clock from the second PLL model
// Notes:   Lock is modelled by a counter; aux counter value crosses by gray code
`timescale 1ns/1ps
`include "scc_map.vh"

module scc_clock_ctrl #(
    parameter LOCK_CYCLES = 1024,
    parameter CNT_W       = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        aux_clk,
    output wire [15:0] gate0_en,
    output wire [15:0] gate1_en,
    output wire [15:0] gate2_en,
    output wire [15:0] gate3_en,
    output wire [4:0]  mpll_mult,
    output wire [1:0]  output_scaler_select,
    output wire [5:0]  mpll_ratio,
    output wire        second_pll_en,
    output wire [1:0]  second_pll_src,
    output wire [3:0]  second_pll_mult,
    output wire        second_pll_lock_flag,
    output wire        aux_system_clock_en,
    output wire        pwm_bus_sel,
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    // Peripheral clock gates, one enable bit per peripheral instance
    reg [15:0]      gate0_q;
    reg [15:0]      gate1_q;
    reg [15:0]      gate2_q;
    reg [15:0]      gate3_q;
    // Main PLL multiplier and output scaler select
    reg [4:0]       mpll_mult_q;
    reg [1:0]       scaler_sel_q;
    // Second PLL enable, reference source and multiplier
    reg             spll_en_q;
    reg [1:0]       spll_src_q;
    reg [3:0]       spll_mult_q;
    // Second PLL lock model
    reg             lock_q;
    reg [15:0]      lock_cnt_q;
    // Bus select and interrupt state
    reg             pwm_cfg_q;
    reg [2:0]       irq_sts_q;
    reg [2:0]       irq_mask_q;
    // Main PLL ratio, built combinationally
    reg [5:0]       ratio_d;

    // Last lock count before the lock flag rises
    localparam [15:0] LOCK_LAST = LOCK_CYCLES[15:0] - 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte offsets, one 32-bit word each, low 16 bits used
    //   0x00 gate register zero: serial port enables
    //   0x04 gate register one: pwm, capture and encoder enables
    //   0x08 gate register two: high-resolution capture enables
    //   0x0c gate register three: USB and DMA enables
    //   0x10 main PLL control: multiplier in bits 4:0
    //   0x14 main PLL status: output scaler select in bits 8:7
    //   0x18 second PLL config: bit 0 enable, bits 2:1 source
    //   0x1c second PLL multiplier: bits 3:0
    //   0x20 second PLL status: bit 0 lock, read only
    //   0x24 aux clock counter: count value, read only
    //   0x28 pwm bus config: bit 0, 0 DMA bus, 1 accelerator bus
    //   0x2c interrupt status: write one to clear
    //   0x30 interrupt mask: same layout as status
    // Writes to read-only or unmapped words are dropped
    // Unmapped or unaligned words read zero and raise pslverr
    // Clocking overview
    //   All registers, the lock model and the interrupt logic run on pclk
    //   Only the aux counter and its gray image run on aux_clk
    //   Nothing but the gray image crosses between the two domains
    //   Both domains share presetn, which clears them together
    //   The gate enables leave as plain levels; the clock tree applies them
    //   The ratio output is a numerator only; the divider lives elsewhere
    //   A main multiplier write takes effect at once here;
    //   software must let the main loop settle before relying on it
    //   The second PLL lock flag is the only status reported back
    //   Event status bits are sticky until software writes a one to them
    //   The interrupt output is a level, never a pulse
    //   Reads have no side effects; clears need an explicit write
    //   The bus select bit is a plain level sampled by the pwm fabric
    //   Software should choose the source before enabling the second PLL
    //   Changing the source alone does not restart the lock model

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes
    // Writes land in the access phase; reads are captured in setup
    wire            wr_en;
    wire            rd_setup;
    wire            rd_ok;
    wire            wr_smult;
    wire            wr_scfg;
    wire            spll_dis;

    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    // Second PLL writes that force the lock model to restart
    assign wr_smult = wr_en & (paddr == `SCC_OFF_SPLL_MULT);
    assign wr_scfg  = wr_en & (paddr == `SCC_OFF_SPLL_CFG);
    assign spll_dis = wr_scfg & ~pwdata[`SCC_SPLL_EN_BIT];

    // Zero-wait slave: every access phase completes at once
    assign pready  = 1'b1;
    // Error flag only during the access phase of an unmapped word
    assign pslverr = psel & penable & ~rd_ok;

    // Word-aligned offsets up to the mask register are mapped
    assign rd_ok = (paddr[1:0] == 2'b00) && (paddr <= `SCC_OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Software-written control registers
    // Unmapped and read-only offsets fall through to the default arm
    // An over-range main multiplier leaves the old setting in place
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate0_q      <= `SCC_RST_GATE;
            gate1_q      <= `SCC_RST_GATE;
            gate2_q      <= `SCC_RST_GATE;
            gate3_q      <= `SCC_RST_GATE;
            mpll_mult_q  <= `SCC_RST_MPLL_CTL;
            scaler_sel_q <= `SCC_RST_SCALER;
            spll_en_q    <= 1'b0;
            spll_src_q   <= `SCC_SPLL_SRC_XTAL;
            spll_mult_q  <= `SCC_RST_SPLL_MULT;
            pwm_cfg_q    <= 1'b0;
            irq_mask_q   <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                // Peripheral gates, each bit one peripheral instance
                `SCC_OFF_GATE0: gate0_q <= pwdata[15:0];
                `SCC_OFF_GATE1: gate1_q <= pwdata[15:0];
                `SCC_OFF_GATE2: gate2_q <= pwdata[15:0];
                `SCC_OFF_GATE3: gate3_q <= pwdata[15:0];
                // Main PLL: multipliers above the limit are refused
                `SCC_OFF_MPLL_CTL: begin
                    if (pwdata[4:0] <= `SCC_MPLL_MULT_MAX)
                        mpll_mult_q <= pwdata[4:0];
                end
                `SCC_OFF_MPLL_STS: begin
                    scaler_sel_q <= pwdata[`SCC_SCALER_LSB+1:`SCC_SCALER_LSB];
                end
                // Second PLL enable, source and multiplier
                `SCC_OFF_SPLL_CFG: begin
                    spll_en_q  <= pwdata[`SCC_SPLL_EN_BIT];
                    spll_src_q <= pwdata[`SCC_SPLL_SRC_LSB+1:`SCC_SPLL_SRC_LSB];
                end
                `SCC_OFF_SPLL_MULT: spll_mult_q <= pwdata[3:0];
                // Bus select and interrupt mask
                `SCC_OFF_PWM_CFG: pwm_cfg_q <= pwdata[0];
                `SCC_OFF_IRQ_MASK: irq_mask_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock model: a count of pclk cycles stands in for the PLL settle time
    // Disable or a multiplier rewrite restarts the count and drops lock
    // Once locked the count holds, so the flag stays up until restarted
    // The model ignores the chosen reference source and multiplier value;
    // a real loop would settle in a time that depends on both
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q     <= 1'b0;
            lock_cnt_q <= 16'h0000;
        end else if (spll_dis || wr_smult || !spll_en_q) begin
            lock_q     <= 1'b0;
            lock_cnt_q <= 16'h0000;
        end else if (lock_cnt_q == LOCK_LAST) begin
            lock_q     <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Aux clock counter, free running in the aux clock domain
    // The count wraps on its own; software never reloads it
    // Gray code lets the pclk side take a multi-bit value safely
    // A read shows the count as it stood two or three pclk cycles earlier
    reg [CNT_W-1:0] aux_cnt_q;
    reg [CNT_W-1:0] aux_gray_q;
    reg [CNT_W-1:0] sync1_q;
    reg [CNT_W-1:0] sync2_q;
    reg [CNT_W-1:0] aux_bin;
    reg             msb_prev_q;
    integer         i;

    // Binary count and its gray image move together
    always @(posedge aux_clk or negedge presetn) begin
        if (!presetn) begin
            aux_cnt_q  <= {CNT_W{1'b0}};
            aux_gray_q <= {CNT_W{1'b0}};
        end else begin
            aux_cnt_q  <= aux_cnt_q + 1'b1;
            aux_gray_q <= (aux_cnt_q + 1'b1) ^ ((aux_cnt_q + 1'b1) >> 1);
        end
    end

    // Two-stage synchroniser into pclk; only the second stage is read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= {CNT_W{1'b0}};
            sync2_q <= {CNT_W{1'b0}};
        end else begin
            sync1_q <= aux_gray_q;
            sync2_q <= sync1_q;
        end
    end

    // Gray to binary, most significant bit first
    always @* begin
        aux_bin          = {CNT_W{1'b0}};
        aux_bin[CNT_W-1] = sync2_q[CNT_W-1];
        for (i = CNT_W - 2; i >= 0; i = i - 1)
            aux_bin[i] = aux_bin[i+1] ^ sync2_q[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events: lock gained, lock lost, counter wrap
    // An event and a write-one clear in one cycle leave the bit set
    wire            lock_rise;
    wire            lock_fall;
    wire            cnt_wrap;
    wire [2:0]      ev;
    wire [2:0]      clr;

    // Lock gained: the count reaches its end with nothing restarting it
    assign lock_rise = ~lock_q & (lock_cnt_q == LOCK_LAST) & spll_en_q
                       & ~spll_dis & ~wr_smult;
    // Lock lost: a locked loop is disabled or given a new multiplier
    assign lock_fall = lock_q & (spll_dis | wr_smult | ~spll_en_q);
    // Wrap: the top bit of the synchronised count falls
    assign cnt_wrap  = msb_prev_q & ~aux_bin[CNT_W-1];
    assign ev        = {cnt_wrap, lock_fall, lock_rise};
    assign clr       = (wr_en && paddr == `SCC_OFF_IRQ_STS) ? pwdata[2:0] : 3'h0;

    // Status bits: a set wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_q  <= 3'h0;
            msb_prev_q <= 1'b0;
        end else begin
            irq_sts_q  <= (irq_sts_q & ~clr) | ev;
            msb_prev_q <= aux_bin[CNT_W-1];
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(irq_sts_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered at the setup phase
    // Held until the next read setup, so it stands through the access
    // Unused upper bits of every register read as zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                `SCC_OFF_GATE0:     prdata <= {16'h0000, gate0_q};
                `SCC_OFF_GATE1:     prdata <= {16'h0000, gate1_q};
                `SCC_OFF_GATE2:     prdata <= {16'h0000, gate2_q};
                `SCC_OFF_GATE3:     prdata <= {16'h0000, gate3_q};
                `SCC_OFF_MPLL_CTL:  prdata <= {27'h0, mpll_mult_q};
                `SCC_OFF_MPLL_STS:  prdata <= {23'h0, scaler_sel_q, 7'h00};
                `SCC_OFF_SPLL_CFG:  prdata <= {29'h0, spll_src_q, spll_en_q};
                `SCC_OFF_SPLL_MULT: prdata <= {28'h0, spll_mult_q};
                `SCC_OFF_SPLL_STS:  prdata <= {31'h0, lock_q};
                `SCC_OFF_AUX_CNT:   prdata <= {{(32-CNT_W){1'b0}}, aux_bin};
                `SCC_OFF_PWM_CFG:   prdata <= {31'h0, pwm_cfg_q};
                `SCC_OFF_IRQ_STS:   prdata <= {29'h0, irq_sts_q};
                `SCC_OFF_IRQ_MASK:  prdata <= {29'h0, irq_mask_q};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main PLL ratio numerator: multiplier scaled by the output scaler select
    // Select 0 and 1 divide by four, 2 divides by two, 3 passes the multiplier
    always @* begin
        ratio_d = {1'b0, mpll_mult_q} >> 2;
        case (scaler_sel_q)
            2'h0:    ratio_d = {1'b0, mpll_mult_q} >> 2;
            2'h1:    ratio_d = {1'b0, mpll_mult_q} >> 2;
            2'h2:    ratio_d = {1'b0, mpll_mult_q} >> 1;
            2'h3:    ratio_d = {1'b0, mpll_mult_q};
            default: ratio_d = {1'b0, mpll_mult_q} >> 2;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the clock tree
    // Peripheral gate enables
    assign gate0_en             = gate0_q;
    assign gate1_en             = gate1_q;
    assign gate2_en             = gate2_q;
    assign gate3_en             = gate3_q;
    // Main PLL settings and ratio
    assign mpll_mult            = mpll_mult_q;
    assign output_scaler_select = scaler_sel_q;
    assign mpll_ratio           = ratio_d;
    // Second PLL settings and lock
    assign second_pll_en        = spll_en_q;
    assign second_pll_src       = spll_src_q;
    assign second_pll_mult      = spll_mult_q;
    assign second_pll_lock_flag = lock_q;
    // Aux system clock runs only once the second PLL is locked
    assign aux_system_clock_en  = spll_en_q & lock_q;
    // Pwm modules on the DMA bus at 0, the accelerator bus at 1
    assign pwm_bus_sel          = pwm_cfg_q;

endmodule

// file: sim/scc_chk.sv
// Purpose: Port assertions for the clock control block
// Assumes: Short lock time in simulation (at least 4 cycles)
// Notes:   Watches a subset of the top ports
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [15:0] gate2_en,
    input wire logic [4:0]  mpll_mult,
    input wire logic [3:0]  second_pll_mult,
    input wire logic        second_pll_en,
    input wire logic        second_pll_lock_flag,
    input wire logic        aux_system_clock_en,
    input wire logic        pwm_bus_sel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write strobe and last write data
    wire wr = psel && penable && pwrite;
    reg [31:0] wd_q;
    always @(posedge pclk) wd_q <= pwdata;
    ////////////////////////////////////////////////////////////////////////////
    mult_take_a: assert property (wr && paddr == `SCC_OFF_MPLL_CTL && pwdata[4:0] <= 5'h10
        |=> mpll_mult == wd_q[4:0]) else $error("main multiplier not taken");
    mult_hold_a: assert property (wr && paddr == `SCC_OFF_MPLL_CTL && pwdata[4:0] > 5'h10
        |=> $stable(mpll_mult)) else $error("main multiplier over limit taken");
    spll_mult_a: assert property (wr && paddr == `SCC_OFF_SPLL_MULT
        |=> second_pll_mult == wd_q[3:0]) else $error("second multiplier not taken");
    lock_drop_a: assert property (wr && (paddr == `SCC_OFF_SPLL_MULT
        || paddr == `SCC_OFF_SPLL_CFG && !pwdata[0]) |=> !second_pll_lock_flag)
        else $error("lock kept");
    lock_wait_a: assert property ($rose(second_pll_en) |-> !second_pll_lock_flag [*4])
        else $error("lock too early");
    aux_en_a: assert property (aux_system_clock_en == (second_pll_en && second_pll_lock_flag))
        else $error("aux clock enable wrong");
    pwm_sel_a: assert property (wr && paddr == `SCC_OFF_PWM_CFG |=> pwm_bus_sel == wd_q[0])
        else $error("bus select wrong");
    gate_two_a: assert property (wr && paddr == `SCC_OFF_GATE2 |=> gate2_en == wd_q[15:0])
        else $error("capture gates wrong");
endmodule
bind scc_clock_ctrl scc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .gate2_en(gate2_en),
    .mpll_mult(mpll_mult), .second_pll_mult(second_pll_mult), .second_pll_en(second_pll_en),
    .second_pll_lock_flag(second_pll_lock_flag), .aux_system_clock_en(aux_system_clock_en),
    .pwm_bus_sel(pwm_bus_sel));

// file: sim/system_clock_control_update_tb.sv
// Purpose: Self-checking bench for the clock control block
// Assumes: Zero-wait APB slave, lock time set to 8
// Notes:   Reads are checked by a monitor from a queue of notes
`timescale 1ns/1ps
`include "scc_map.vh"
module system_clock_control_update_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, aux_clk = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, x = 32'hd840, v;
    reg err = 0;
    wire [31:0] prdata;
    wire pready, pslverr, second_pll_en, second_pll_lock_flag, aux_system_clock_en, pwm_bus_sel, irq;
    wire [15:0] gate0_en, gate1_en, gate2_en, gate3_en;
    wire [4:0] mpll_mult;
    wire [1:0] output_scaler_select, second_pll_src;
    wire [5:0] mpll_ratio;
    wire [3:0] second_pll_mult;
    integer failures = 0, checks = 0, i;
    logic [31:0] q[$];
    scc_clock_ctrl #(.LOCK_CYCLES(8)) dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .aux_clk              (aux_clk),
        .gate0_en             (gate0_en),
        .gate1_en             (gate1_en),
        .gate2_en             (gate2_en),
        .gate3_en             (gate3_en),
        .mpll_mult            (mpll_mult),
        .output_scaler_select (output_scaler_select),
        .mpll_ratio           (mpll_ratio),
        .second_pll_en        (second_pll_en),
        .second_pll_src       (second_pll_src),
        .second_pll_mult      (second_pll_mult),
        .second_pll_lock_flag (second_pll_lock_flag),
        .aux_system_clock_en  (aux_system_clock_en),
        .pwm_bus_sel          (pwm_bus_sel),
        .irq                  (irq)
    );
    // Clocks, aux clock unrelated in phase
    always #10 pclk = ~pclk;
    always #7 aux_clk = ~aux_clk;
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input string n, input logic [31:0] s, e);
        checks = checks + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // One APB transfer, read data left in v
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        v = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rd(input [11:0] a, input [31:0] e);
        q.push_back(e);
        apb(0, a, 0);
    endtask
    task final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Read monitor takes the oldest note
    always @(posedge pclk) if (psel && penable && !pwrite && pready && q.size() > 0)
        chk("prdata", prdata, q.pop_front());
    initial begin
        repeat (5000) @(posedge pclk);
        failures = failures + 1;
        final_report;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        chk("second_pll_src", second_pll_src, 0);
        for (i = 0; i < 36; i = i + 4) rd(i[11:0], 0);
        for (i = 0; i < 4; i = i + 1) begin
            x = xs(x);
            apb(1, i[9:0] * 4, x);
            #1 v = i == 0 ? gate0_en : i == 1 ? gate1_en : i == 2 ? gate2_en : gate3_en;
            chk("gate_en", v, x & 32'hffff);
            rd(i[9:0] * 4, x & 32'hffff);
        end
        chk("gate3_en", gate3_en, x[15:0]);
        apb(1, `SCC_OFF_MPLL_CTL, 32'h10);
        apb(1, `SCC_OFF_MPLL_CTL, 32'h11);
        rd(`SCC_OFF_MPLL_CTL, 32'h10);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, `SCC_OFF_MPLL_STS, i << 7);
            #1 chk("mpll_ratio", mpll_ratio, 16 >> (i < 2 ? 2 : 3 - i));
            chk("output_scaler_select", output_scaler_select, i);
        end
        apb(1, `SCC_OFF_SPLL_MULT, 32'hf);
        rd(`SCC_OFF_SPLL_MULT, 32'hf);
        chk("pslverr", err, 0);
        apb(1, `SCC_OFF_IRQ_MASK, 1);
        apb(1, `SCC_OFF_SPLL_CFG, 1);
        #1 chk("second_pll_en", second_pll_en, 1);
        for (i = 0; i < 50 && second_pll_lock_flag !== 1'b1; i = i + 1) @(posedge pclk);
        rd(`SCC_OFF_SPLL_STS, 1);
        chk("irq", irq, 1);
        chk("aux_system_clock_en", aux_system_clock_en, 1);
        apb(1, `SCC_OFF_IRQ_STS, 1);
        apb(1, `SCC_OFF_SPLL_MULT, 32'h3);
        #1 chk("irq", irq, 0);
        chk("aux_system_clock_en", aux_system_clock_en, 0);
        rd(`SCC_OFF_SPLL_STS, 0);
        apb(0, `SCC_OFF_AUX_CNT, 0);
        x = v;
        repeat (5) @(posedge pclk);
        apb(0, `SCC_OFF_AUX_CNT, 0);
        chk("aux_count_moves", v !== x, 1);
        chk("aux_count_high", v >> 16, 0);
        apb(1, `SCC_OFF_PWM_CFG, 1);
        rd(`SCC_OFF_PWM_CFG, 1);
        chk("pwm_bus_sel", pwm_bus_sel, 1);
        rd(12'h100, 0);
        chk("pslverr", err, 1);
        final_report;
    end
endmodule
